/* File: rtl/sqm_monitor.sv */
`timescale 1ns/1ps
`include "sqm_defs.svh"

module sqm_monitor import sqm_pkg::*; #(
	parameter int unsigned HOLD_STEP_S = `SQM_HOLD_STEP_S,
	parameter int unsigned NOSIG_TIMEOUT_S = `SQM_NOSIG_TIMEOUT_S
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// Timing reference
	input wire logic pps_i,
	input wire logic ref_locked_i,
	input wire logic meas_valid_i,
	input wire logic [`SQM_ERR_W-1:0] time_err_ns_i,
	input wire logic antenna_present_i,
	// Network setup
	input wire logic net_cfg_done_i,
	// Grade and link quality
	output logic [`SQM_FIG_W-1:0] accuracy_figure_o,
	output logic phy_sync_en_o,
	output logic esmc_send_o,
	output logic [`SQM_QL_W-1:0] esmc_ql_o,
	output logic [`SQM_QL_W-1:0] status_ql_o,
	output logic ql_prc_o,
	// Alarms and faults
	output logic antenna_alarm_o,
	output logic alarm_led_o,
	output logic fault_no_signal_o,
	// Time server advertisement
	output logic [`SQM_STRATUM_W-1:0] ntp_stratum_o,
	output logic [1:0] ntp_leap_o
);

	sqm_state_t st_ff;
	sqm_state_t nxt_st;
	logic [`SQM_FIG_W-1:0] meas_fig;
	logic tick;
	logic ref_ok;
	logic hold_step;
	logic nosig_end;

	// Grade of the present measurement
	sqm_fom_enc u_fom_enc (
		.err_ns_i(time_err_ns_i),
		.fig_o(meas_fig)
	);

	// Disciplined second edge drives all per-second work
	assign tick = pps_i & ~st_ff.pps_d;
	// Antenna loss counts as reference loss, too
	assign ref_ok = ref_locked_i & meas_valid_i & antenna_present_i;
	assign hold_step = (st_ff.hold_sec == `SQM_CNT_W'(HOLD_STEP_S - 1));
	assign nosig_end = (st_ff.nosig_sec == `SQM_CNT_W'(NOSIG_TIMEOUT_S - 1));

	// Next state of the whole monitor
	always_comb begin
		nxt_st = st_ff;
		nxt_st.pps_d = pps_i;
		nxt_st.esmc_send = 1'b0;

		// Setup completion is sticky; link waits for it
		if (net_cfg_done_i) begin
			nxt_st.cfg_done = 1'b1;
		end

		// Grade tracking, updated once per second
		if (tick) begin
			case (st_ff.mode)
				SQM_NEVER: begin
					if (ref_ok && meas_fig != `SQM_FIG_UNSYNC) begin
						nxt_st.mode = SQM_LOCKED;
						nxt_st.fig = meas_fig;
					end else begin
						nxt_st.fig = `SQM_FIG_UNSYNC;
					end
				end
				SQM_LOCKED: begin
					if (ref_ok) begin
						nxt_st.fig = meas_fig;
						if (meas_fig == `SQM_FIG_UNSYNC) begin
							nxt_st.mode = SQM_UNSYNC;
						end
					end else begin
						// Keep the last grade; drift model starts now
						nxt_st.mode = SQM_HOLDOVER;
						nxt_st.hold_sec = '0;
					end
				end
				SQM_HOLDOVER: begin
					if (ref_ok) begin
						nxt_st.mode = SQM_LOCKED;
						nxt_st.fig = meas_fig;
						if (meas_fig == `SQM_FIG_UNSYNC) begin
							nxt_st.mode = SQM_UNSYNC;
						end
					end else if (hold_step) begin
						// Worst-case drift: one grade per step, never a jump
						nxt_st.hold_sec = '0;
						nxt_st.fig = st_ff.fig + 4'h1;
						if (st_ff.fig + 4'h1 == `SQM_FIG_UNSYNC) begin
							nxt_st.mode = SQM_UNSYNC;
						end
					end else begin
						nxt_st.hold_sec = st_ff.hold_sec + 1'b1;
					end
				end
				SQM_UNSYNC: begin
					if (ref_ok && meas_fig != `SQM_FIG_UNSYNC) begin
						nxt_st.mode = SQM_LOCKED;
						nxt_st.fig = meas_fig;
					end
				end
				default: begin
					nxt_st.mode = SQM_NEVER;
					nxt_st.fig = `SQM_FIG_UNSYNC;
				end
			endcase
		end

		// No-signal timer runs only while graded unsynchronized
		if (nxt_st.fig != `SQM_FIG_UNSYNC) begin
			nxt_st.nosig_sec = '0;
			nxt_st.nosig_fault = 1'b0;
		end else if (tick && !st_ff.nosig_fault) begin
			if (nosig_end) begin
				nxt_st.nosig_fault = 1'b1;
			end else begin
				nxt_st.nosig_sec = st_ff.nosig_sec + 1'b1;
			end
		end

		// Antenna loss alarms at once, without waiting for the extrapolation
		nxt_st.antenna_alarm = ~antenna_present_i;
		nxt_st.alarm_led = ~antenna_present_i | nxt_st.nosig_fault;

		// Quality level follows the grade
		if (nxt_st.fig <= `SQM_FIG_PRC_MAX) begin
			nxt_st.ql_prc = 1'b1;
			nxt_st.status_ql = `SQM_QL_PRC;
		end else begin
			nxt_st.ql_prc = 1'b0;
			nxt_st.status_ql = `SQM_QL_DNU;
		end

		// Frequency on the physical layer, enabled after setup
		nxt_st.phy_en = nxt_st.cfg_done;

		// Message frame on the data link, one per second edge
		if (tick && st_ff.cfg_done) begin
			nxt_st.esmc_send = 1'b1;
			nxt_st.esmc_ql = nxt_st.status_ql;
		end

		// Time server: stop clients once unsynchronized
		if (nxt_st.fig == `SQM_FIG_UNSYNC) begin
			nxt_st.stratum = `SQM_STRATUM_UNSYNC;
			nxt_st.leap = `SQM_LEAP_FAULT;
		end else begin
			nxt_st.stratum = `SQM_STRATUM_SYNC;
			nxt_st.leap = `SQM_LEAP_OK;
		end
	end

	// Single state register
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			st_ff <= SQM_STATE_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from the state register
	assign accuracy_figure_o = st_ff.fig;
	assign phy_sync_en_o = st_ff.phy_en;
	assign esmc_send_o = st_ff.esmc_send;
	assign esmc_ql_o = st_ff.esmc_ql;
	assign status_ql_o = st_ff.status_ql;
	assign ql_prc_o = st_ff.ql_prc;
	assign antenna_alarm_o = st_ff.antenna_alarm;
	assign alarm_led_o = st_ff.alarm_led;
	assign fault_no_signal_o = st_ff.nosig_fault;
	assign ntp_stratum_o = st_ff.stratum;
	assign ntp_leap_o = st_ff.leap;

	// Checks on the monitor's own outputs
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	// Grade never leaves its range
	property p_fig_range;
		st_ff.fig >= `SQM_FIG_BEST && st_ff.fig <= `SQM_FIG_UNSYNC;
	endproperty
	a_fig_range: assert property (p_fig_range)
		else $error("accuracy figure out of range");

	// Good grade reports primary reference level
	property p_prc_level;
		st_ff.fig <= `SQM_FIG_PRC_MAX |-> st_ff.ql_prc && st_ff.status_ql == `SQM_QL_PRC;
	endproperty
	a_prc_level: assert property (p_prc_level)
		else $error("good grade without primary level");

	// Poor grade reports do-not-use level
	property p_dnu_level;
		st_ff.fig > `SQM_FIG_PRC_MAX |-> !st_ff.ql_prc && st_ff.status_ql == `SQM_QL_DNU;
	endproperty
	a_dnu_level: assert property (p_dnu_level)
		else $error("poor grade without do-not-use level");

	// Every second edge after setup yields one message carrying the level
	property p_esmc_on_tick;
		tick && st_ff.cfg_done |=> esmc_send_o && esmc_ql_o == status_ql_o;
	endproperty
	a_esmc_on_tick: assert property (p_esmc_on_tick)
		else $error("second edge without status message");

	// Messages only on a second edge, only after setup
	property p_esmc_cause;
		esmc_send_o |-> $past(tick) && $past(st_ff.cfg_done) ##1 !esmc_send_o;
	endproperty
	a_esmc_cause: assert property (p_esmc_cause)
		else $error("status message without second edge or setup");

	// Outage after lock degrades at most one grade per clock cycle
	property p_holdover_gradual;
		st_ff.mode == SQM_HOLDOVER && !ref_ok |=>
			st_ff.fig >= $past(st_ff.fig) && st_ff.fig <= $past(st_ff.fig) + 4'h1;
	endproperty
	a_holdover_gradual: assert property (p_holdover_gradual)
		else $error("holdover grade jumped");

	// Antenna removal alarms on the next edge
	property p_antenna_alarm;
		!antenna_present_i |=> antenna_alarm_o && alarm_led_o;
	endproperty
	a_antenna_alarm: assert property (p_antenna_alarm)
		else $error("antenna removal not alarmed");

	// No-signal fault only while unsynchronized and after the full count
	property p_nosig_fault;
		$rose(fault_no_signal_o) |->
			st_ff.fig == `SQM_FIG_UNSYNC && $past(nosig_end) && alarm_led_o;
	endproperty
	a_nosig_fault: assert property (p_nosig_fault)
		else $error("no-signal fault without timeout");

	// Unsynchronized grade advertises stratum 16 and fault leap bits
	property p_ntp_unsync;
		st_ff.fig == `SQM_FIG_UNSYNC |->
			ntp_stratum_o == `SQM_STRATUM_UNSYNC && ntp_leap_o == `SQM_LEAP_FAULT;
	endproperty
	a_ntp_unsync: assert property (p_ntp_unsync)
		else $error("unsynchronized without stratum 16");

	// Setup completion turns on the physical-layer reference on the next edge
	property p_phy_after_cfg;
		net_cfg_done_i |=> phy_sync_en_o;
	endproperty
	a_phy_after_cfg: assert property (p_phy_after_cfg)
		else $error("setup done without physical-layer enable");

	// No status frame while the link still waits for setup
	property p_no_frame_before_cfg;
		!phy_sync_en_o |-> !esmc_send_o;
	endproperty
	a_no_frame_before_cfg: assert property (p_no_frame_before_cfg)
		else $error("status message before network setup");

	// A held pulse is one second edge, never a second frame
	property p_pps_held_once;
		pps_i && st_ff.pps_d |=> !esmc_send_o;
	endproperty
	a_pps_held_once: assert property (p_pps_held_once)
		else $error("held second pulse sent a frame");

	// Between frames the carried level stays put
	property p_frame_level_hold;
		!esmc_send_o |-> $stable(esmc_ql_o);
	endproperty
	a_frame_level_hold: assert property (p_frame_level_hold)
		else $error("frame level changed without a frame");

	// Holdover keeps a usable grade and raises no fault
	property p_holdover_quiet;
		st_ff.mode == SQM_HOLDOVER |-> !fault_no_signal_o && st_ff.fig != `SQM_FIG_UNSYNC;
	endproperty
	a_holdover_quiet: assert property (p_holdover_quiet)
		else $error("holdover raised a fault");

	// The fault always shows on the indicator, and only at grade 9
	property p_fault_led;
		fault_no_signal_o |-> alarm_led_o && accuracy_figure_o == `SQM_FIG_UNSYNC;
	endproperty
	a_fault_led: assert property (p_fault_led)
		else $error("no-signal fault without indicator");

endmodule

/* File: rtl/sqm_defs.svh */
`ifndef SQM_DEFS_SVH
`define SQM_DEFS_SVH

// Accuracy figure grades
`define SQM_FIG_W 4
`define SQM_FIG_BEST 4'h3
`define SQM_FIG_PRC_MAX 4'h4
`define SQM_FIG_UNSYNC 4'h9
`define SQM_FIG_STEPS 6

// Time error bounds in nanoseconds, one per grade step
`define SQM_ERR_W 32
`define SQM_ERR_100NS 32'h0000_0064
`define SQM_ERR_1US 32'h0000_03E8
`define SQM_ERR_10US 32'h0000_2710
`define SQM_ERR_100US 32'h0001_86A0
`define SQM_ERR_1MS 32'h000F_4240
`define SQM_ERR_10MS 32'h0098_9680

// Quality level codes carried in the status message
`define SQM_QL_W 4
`define SQM_QL_PRC 4'h2
`define SQM_QL_DNU 4'hF

// Time server advertisement
`define SQM_STRATUM_W 5
`define SQM_STRATUM_SYNC 5'h01
`define SQM_STRATUM_UNSYNC 5'h10
`define SQM_LEAP_OK 2'h0
`define SQM_LEAP_FAULT 2'h3

// Second counters, counted on the one-second pulse
`define SQM_CNT_W 16
`define SQM_NOSIG_TIMEOUT_S 3600
`define SQM_HOLD_STEP_S 600

`endif

/* File: rtl/sqm_pkg.sv */
`include "sqm_defs.svh"

package sqm_pkg;

	// Reference tracking mode
	typedef enum logic [1:0] {
		SQM_NEVER,
		SQM_LOCKED,
		SQM_HOLDOVER,
		SQM_UNSYNC
	} sqm_mode_t;

	// Whole state of the monitor
	typedef struct packed {
		sqm_mode_t mode;
		logic pps_d;
		logic cfg_done;
		logic [`SQM_FIG_W-1:0] fig;
		logic [`SQM_CNT_W-1:0] hold_sec;
		logic [`SQM_CNT_W-1:0] nosig_sec;
		logic nosig_fault;
		logic antenna_alarm;
		logic alarm_led;
		logic phy_en;
		logic esmc_send;
		logic [`SQM_QL_W-1:0] esmc_ql;
		logic [`SQM_QL_W-1:0] status_ql;
		logic ql_prc;
		logic [`SQM_STRATUM_W-1:0] stratum;
		logic [1:0] leap;
	} sqm_state_t;

	localparam sqm_state_t SQM_STATE_RST = '{
		mode: SQM_NEVER,
		pps_d: 1'b0,
		cfg_done: 1'b0,
		fig: `SQM_FIG_UNSYNC,
		hold_sec: '0,
		nosig_sec: '0,
		nosig_fault: 1'b0,
		antenna_alarm: 1'b0,
		alarm_led: 1'b0,
		phy_en: 1'b0,
		esmc_send: 1'b0,
		esmc_ql: `SQM_QL_DNU,
		status_ql: `SQM_QL_DNU,
		ql_prc: 1'b0,
		stratum: `SQM_STRATUM_UNSYNC,
		leap: `SQM_LEAP_FAULT
	};

endpackage

/* File: rtl/sqm_fom_enc.sv */
`timescale 1ns/1ps
`include "sqm_defs.svh"

// Grades a measured time error into the accuracy figure
module sqm_fom_enc import sqm_pkg::*; (
	// Measured time error, nanoseconds
	input wire logic [`SQM_ERR_W-1:0] err_ns_i,
	// Grade 3 to 9
	output logic [`SQM_FIG_W-1:0] fig_o
);

	localparam logic [`SQM_ERR_W-1:0] BOUND [`SQM_FIG_STEPS] = '{
		`SQM_ERR_100NS, `SQM_ERR_1US, `SQM_ERR_10US,
		`SQM_ERR_100US, `SQM_ERR_1MS, `SQM_ERR_10MS
	};

	logic [`SQM_FIG_STEPS-1:0] over;

	// One comparator per bound; bounds rise, so grade 3 plus the count is the grade
	genvar gi;
	generate
		for (gi = 0; gi < `SQM_FIG_STEPS; gi++) begin : g_bound
			assign over[gi] = (err_ns_i >= BOUND[gi]);
		end
	endgenerate

	// Exactly 10 ms lands on 9, matching the "not below 10 ms" grade
	always_comb begin
		fig_o = `SQM_FIG_BEST;
		for (int i = 0; i < `SQM_FIG_STEPS; i++) begin
			fig_o = fig_o + {3'h0, over[i]};
		end
	end

endmodule

/* File: tb/sqm_link_peer.sv */
`timescale 1ns/1ps
`include "sqm_defs.svh"

// Downstream equipment that takes its status frames from the link
module sqm_link_peer (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// Status frame from the monitor
	input wire logic esmc_send_i,
	input wire logic [`SQM_QL_W-1:0] esmc_ql_i,
	// What the peer has taken
	output int frame_cnt_o,
	output logic [`SQM_QL_W-1:0] last_ql_o
);
	// Level trusted only in the send cycle, as a real receiver would
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			frame_cnt_o <= 0;
			last_ql_o <= 4'h0;
		end else if (esmc_send_i) begin
			frame_cnt_o <= frame_cnt_o + 1;
			last_ql_o <= esmc_ql_i;
		end
	end
endmodule

/* File: tb/sync_quality_monitor_tb.sv */
`timescale 1ns/1ps
`include "sqm_defs.svh"

module sync_quality_monitor_tb;
	import sqm_pkg::*;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic pps_i = 1'b0;
	logic ref_locked_i = 1'b0;
	logic meas_valid_i = 1'b0;
	logic [31:0] time_err_ns_i = 32'h0;
	logic antenna_present_i = 1'b1;
	logic net_cfg_done_i = 1'b0;
	logic [3:0] fig;
	logic phy_en, send, prc, ant_al, led, fault;
	logic [3:0] eql, sql, pql, q, prev;
	logic [4:0] strat;
	logic [1:0] leap;
	int frames, n, n_mismatch = 0, samples_checked = 0;
	logic [31:0] errs [12] = '{32'h63, 32'h64, 32'h3E7, 32'h3E8, 32'h270F, 32'h2710,
		32'h1869F, 32'h186A0, 32'hF423F, 32'hF4240, 32'h98967F, 32'h989680};
	logic [3:0] figs [12] = '{4'h3, 4'h4, 4'h4, 4'h5, 4'h5, 4'h6, 4'h6, 4'h7, 4'h7,
		4'h8, 4'h8, 4'h9};

	// Short counts so a timeout is a few ticks, not an hour
	sqm_monitor #(.HOLD_STEP_S(2), .NOSIG_TIMEOUT_S(3)) i_dut (
		.clk_sys_i(clk_sys_i), .reset_i(reset_i), .pps_i(pps_i),
		.ref_locked_i(ref_locked_i), .meas_valid_i(meas_valid_i),
		.time_err_ns_i(time_err_ns_i), .antenna_present_i(antenna_present_i),
		.net_cfg_done_i(net_cfg_done_i), .accuracy_figure_o(fig),
		.phy_sync_en_o(phy_en), .esmc_send_o(send), .esmc_ql_o(eql),
		.status_ql_o(sql), .ql_prc_o(prc), .antenna_alarm_o(ant_al),
		.alarm_led_o(led), .fault_no_signal_o(fault), .ntp_stratum_o(strat),
		.ntp_leap_o(leap));

	sqm_link_peer i_peer (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.esmc_send_i(send), .esmc_ql_i(eql), .frame_cnt_o(frames), .last_ql_o(pql));

	// 100 MHz
	always #5 clk_sys_i = ~clk_sys_i;

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic do_reset();
		@(posedge clk_sys_i);
		reset_i <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		@(posedge clk_sys_i);
		#1;
	endtask

	// One second tick; returns just after the edge that takes it
	task automatic tick(input logic lk, input logic [31:0] e);
		@(posedge clk_sys_i);
		pps_i <= 1'b1;
		ref_locked_i <= lk;
		meas_valid_i <= lk;
		time_err_ns_i <= e;
		@(posedge clk_sys_i);
		pps_i <= 1'b0;
		#1;
	endtask

	task automatic t_reset_cfg();
		do_reset();
		chk(fig, `SQM_FIG_UNSYNC);
		chk(sql, `SQM_QL_DNU);
		chk({leap, strat}, {`SQM_LEAP_FAULT, `SQM_STRATUM_UNSYNC});
		tick(1'b1, 32'h1F4);
		chk({phy_en, send, frames}, 34'h0);
		@(posedge clk_sys_i);
		net_cfg_done_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk(phy_en, 1'b1);
		$display("test reset_cfg done");
	endtask

	task automatic t_grade();
		n = frames;
		for (int i = 0; i < 12; i++) begin
			tick(1'b1, errs[i]);
			q = (figs[i] <= 4'h4) ? `SQM_QL_PRC : `SQM_QL_DNU;
			chk(fig, figs[i]);
			chk({send, eql, sql}, {1'b1, q, q});
			chk(prc, figs[i] <= 4'h4);
			chk(strat, (figs[i] == 4'h9) ? `SQM_STRATUM_UNSYNC : `SQM_STRATUM_SYNC);
			chk(leap, (figs[i] == 4'h9) ? `SQM_LEAP_FAULT : `SQM_LEAP_OK);
			@(posedge clk_sys_i);
			#1;
			chk({send, frames, pql}, {1'b0, n + i + 1, q});
		end
		$display("test grade done");
	endtask

	task automatic t_pps_hold();
		n = frames;
		// One long pulse: only its rising edge may send
		@(posedge clk_sys_i);
		pps_i <= 1'b1;
		ref_locked_i <= 1'b1;
		meas_valid_i <= 1'b1;
		time_err_ns_i <= 32'h1F4;
		repeat (5) @(posedge clk_sys_i);
		pps_i <= 1'b0;
		repeat (30) @(posedge clk_sys_i);
		#1;
		chk(frames, n + 1);
		chk({fig, prc, pql}, {4'h4, 1'b1, `SQM_QL_PRC});
		$display("test pps_hold done");
	endtask

	task automatic t_holdover();
		// Brief outage keeps the grade, then a good second relocks
		tick(1'b0, 32'h0);
		chk({fig, led, ant_al}, {4'h4, 2'h0});
		tick(1'b1, 32'h32);
		chk({fig, prc, led}, {4'h3, 2'h2});
		prev = fig;
		for (int i = 0; i < 14; i++) begin
			tick(1'b0, 32'h0);
			chk((fig >= prev) && (fig <= prev + 4'h1), 1'b1);
			chk((fig == 4'h9) || (led == 1'b0 && ant_al == 1'b0), 1'b1);
			prev = fig;
		end
		chk({fig, strat, leap}, {`SQM_FIG_UNSYNC, `SQM_STRATUM_UNSYNC, `SQM_LEAP_FAULT});
		$display("test holdover done");
	endtask

	task automatic t_nosig();
		do_reset();
		// Timeout is three seconds at grade 9; the third sets the fault
		repeat (2) begin
			tick(1'b0, 32'h0);
			chk({fault, led}, 2'h0);
		end
		tick(1'b0, 32'h0);
		chk({fault, led, fig}, {2'h3, `SQM_FIG_UNSYNC});
		tick(1'b1, 32'h32);
		chk({fig, fault, led}, {4'h3, 2'b00});
		$display("test nosig done");
	endtask

	task automatic t_antenna();
		@(posedge clk_sys_i);
		antenna_present_i <= 1'b0;
		@(posedge clk_sys_i);
		#1;
		chk({ant_al, led, fig}, {2'b11, 4'h3});
		@(posedge clk_sys_i);
		antenna_present_i <= 1'b1;
		@(posedge clk_sys_i);
		#1;
		chk({ant_al, led}, 2'b00);
		$display("test antenna done");
	endtask

	// Main sequence
	initial begin
		t_reset_cfg();
		t_grade();
		t_pps_hold();
		t_holdover();
		t_nosig();
		t_antenna();
		report_and_stop();
	end

	// Watchdog, far beyond the roughly 135 cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		n_mismatch++;
		report_and_stop();
	end
endmodule
